// ---- verilog/spg_pkg.sv ----
// constants shared by the protection device end and the host controller end
// Summary of operation
// RQ1 - all-ones bits five..two globally protect all
// RQ2 - all-zeros bits five..two globally unprotect all
// RQ3 - other patterns leave protection unchanged
// RQ4 - pin low with lock: refuse everything
// RQ5 - pin high with lock: only lock clear
// RQ6 - host rewrites status after lock clears
// RQ7 - unlocked write loads lock with global
// RQ8 - host uses no-change pattern for lock
// RQ9 - store only bit seven of written byte
// RQ10 - status read shows pin and summary
// RQ11 - global protect aborts while suspended
// RQ12 - protection read: opcode plus three address
// RQ13 - repeating all-ones or all-zeros output byte
// RQ14 - fast host discards first output byte
// RQ15 - select high ends read, floats output
// RQ16 - protection read ignores the pin
// RQ17 - summary bits give all, some, none
// RQ18 - every sector starts protected
// RQ19 - status write needs write permit latch
// RQ20 - hard lock is pin low and lock
// RQ21 - update at select rise on byte boundary
// RQ22 - sixty-four sectors, upper address selects
`default_nettype none
package spg_pkg;
  // opcodes understood by the device
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_RD_PROT = 8'h3C;
  // sector map
  localparam int SECT_BITS = 6;
  localparam int NUM_SECT = 64;
  localparam logic [63:0] PROT_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
  // status byte one layout
  localparam int ST_LOCK = 7;
  localparam int ST_PIN = 4;
  localparam int ST_SUM_HI = 3;
  localparam int ST_SUM_LO = 2;
  localparam int ST_WPL = 1;
  localparam int GSEL_HI = 5;
  localparam int GSEL_LO = 2;
  localparam logic [3:0] GSEL_ALL = 4'hF;
  localparam logic [3:0] GSEL_NONE = 4'h0;
  localparam logic [1:0] SUM_NONE = 2'h0;
  localparam logic [1:0] SUM_SOME = 2'h1;
  localparam logic [1:0] SUM_ALL = 2'h3;
  // host wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  // control register fields
  localparam int CT_OP_LO = 0;
  localparam int CT_USE_ADDR = 8;
  localparam int CT_EXTRA_LO = 9;
  localparam int CT_WP_N = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0001_0000;
  // link clock timing
  localparam int SYS_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int SCK_HALF = (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;
endpackage
`default_nettype wire

// ---- verilog/spg_if.sv ----
// serial link between the protection device and its host controller
`timescale 1ns/1ps
`default_nettype none
interface spg_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic wp_n;
  wire so_line;
  // a released line shows the inverse of miso, which the device holds low while released, so it reads high
  assign so_line = miso_oe_n ? ~miso : miso;
  modport dev (input cs_n, input sck, input mosi, input wp_n, output miso, output miso_oe_n);
  modport host (output cs_n, output sck, output mosi, output wp_n, input so_line);
endinterface
`default_nettype wire

// ---- verilog/spg_dev.sv ----
// protection device end: global protect/unprotect, lock bit, sector protection read
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spg_dev (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SUSPEND,
  spg_if.dev LINK,
  output logic [63:0] PROT_MAP,
  output logic LOCK,
  output logic WRITE_PERMIT,
  output logic [7:0] STATUS
);
  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic mosi_s1_q, mosi_s2_q;
  logic wp_s1_q, wp_s2_q;
  logic sck_rise, sck_fall, cs_rise;

  // two flops per pin; a third copy only feeds edge detection
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= LINK.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sck_s1_q <= LINK.sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      mosi_s1_q <= LINK.mosi;
      mosi_s2_q <= mosi_s1_q;
      wp_s1_q <= LINK.wp_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  // edges seen only while selected; a stopped clock gives none
  assign sck_rise = sck_s2_q & ~sck_s3_q & ~cs_s2_q;
  assign sck_fall = ~sck_s2_q & sck_s3_q & ~cs_s2_q;
  assign cs_rise = cs_s2_q & ~cs_s3_q;

  //////////////////////////////////////////////////////////////////////////
  // frame shifter and byte counting
  logic [2:0] bit_ph_q;
  logic [2:0] byte_cnt_q;
  logic [6:0] sr_q;
  logic [7:0] byte_in;
  logic [7:0] cmd_q;
  logic [7:0] byte1_q;
  logic [spg_pkg::SECT_BITS-1:0] sect_q;

  assign byte_in = {sr_q, mosi_s2_q};

  // counters restart whenever select is high, so each frame begins clean
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bit_ph_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      sr_q <= 7'h00;
    end else if (cs_s2_q) begin
      bit_ph_q <= 3'h0;
      byte_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      sr_q <= byte_in[6:0];
      bit_ph_q <= bit_ph_q + 3'h1;
      // saturate: bytes after the seventh all look the same
      if (bit_ph_q == 3'h7 && byte_cnt_q != 3'h7) begin
        byte_cnt_q <= byte_cnt_q + 3'h1;
      end
    end
  end

  // opcode, first data or address byte, and sector index
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_q <= 8'h00;
      byte1_q <= 8'h00;
      sect_q <= '0;
    end else if (cs_s2_q) begin
      cmd_q <= 8'h00;
    end else if (sck_rise && bit_ph_q == 3'h7) begin
      if (byte_cnt_q == 3'h0) begin
        cmd_q <= byte_in;
      end
      if (byte_cnt_q == 3'h1) begin
        byte1_q <= byte_in;
        sect_q <= byte_in[spg_pkg::SECT_BITS-1:0]; // [RQ22] [RQ12]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // end of frame decode
  logic frame_ok;
  logic wrsr_ok;
  logic hw_lock;
  logic [3:0] gsel;
  logic wpl_q;
  logic lock_q;

  // a command counts only when select rises on a whole byte
  assign frame_ok = cs_rise & (bit_ph_q == 3'h0); // [RQ21]
  assign wrsr_ok = frame_ok & (cmd_q == spg_pkg::OP_WR_STAT) & (byte_cnt_q >= 3'h2) & wpl_q; // [RQ19] [RQ21]
  assign hw_lock = ~wp_s2_q & lock_q; // [RQ20]
  assign gsel = byte1_q[spg_pkg::GSEL_HI:spg_pkg::GSEL_LO]; // [RQ9]

  //////////////////////////////////////////////////////////////////////////
  // write permit latch

  // every status write that ends on a byte boundary, taken or refused, leaves the latch clear
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wpl_q <= 1'b0;
    end else if (frame_ok && byte_cnt_q != 3'h0) begin
      if (cmd_q == spg_pkg::OP_WR_EN) begin
        wpl_q <= 1'b1;
      end else if (cmd_q == spg_pkg::OP_WR_DIS || cmd_q == spg_pkg::OP_WR_STAT) begin
        wpl_q <= 1'b0; // [RQ19]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // lock bit

  // only bit seven of the written byte is ever stored
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lock_q <= 1'b0;
    end else if (wrsr_ok && !hw_lock) begin // [RQ4]
      if (lock_q) begin
        lock_q <= byte1_q[spg_pkg::ST_LOCK]; // [RQ5] may only fall here
      end else begin
        lock_q <= byte1_q[spg_pkg::ST_LOCK]; // [RQ7] [RQ9]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sector protection bits
  logic [spg_pkg::NUM_SECT-1:0] prot_q;

  // global change only when the lock was already clear before this write;
  // clearing a soft lock needs a second write to change sectors
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prot_q <= spg_pkg::PROT_RESET; // [RQ18]
    end else if (wrsr_ok && !lock_q) begin // [RQ4] [RQ5] [RQ6]
      if (gsel == spg_pkg::GSEL_ALL && !SUSPEND) begin // [RQ11]
        prot_q <= spg_pkg::PROT_RESET; // [RQ1]
      end else if (gsel == spg_pkg::GSEL_NONE) begin
        prot_q <= '0; // [RQ2]
      end
      // any other pattern keeps the map as it is [RQ3]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status byte
  logic [7:0] stat_q;
  logic [1:0] summary;

  // summary bits tell all, some or none protected
  always_comb begin
    if (&prot_q) begin
      summary = spg_pkg::SUM_ALL; // [RQ17]
    end else if (|prot_q) begin
      summary = spg_pkg::SUM_SOME;
    end else begin
      summary = spg_pkg::SUM_NONE;
    end
  end

  // written bits five..two never appear; bit five reads zero, pin and summary fill bits four..two
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= 8'h00;
      stat_q[spg_pkg::ST_LOCK] <= lock_q;
      stat_q[spg_pkg::ST_PIN] <= wp_s2_q; // [RQ10]
      stat_q[spg_pkg::ST_SUM_HI:spg_pkg::ST_SUM_LO] <= summary; // [RQ10] [RQ17]
      stat_q[spg_pkg::ST_WPL] <= wpl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial out
  logic miso_q, oe_n_q;

  // new bit on each falling edge; the output floats the moment select is seen high
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (cs_s2_q) begin
      miso_q <= 1'b0;
      oe_n_q <= 1'b1; // [RQ15]
    end else if (sck_fall) begin
      if (cmd_q == spg_pkg::OP_RD_PROT && byte_cnt_q >= 3'h4) begin
        miso_q <= prot_q[sect_q]; // [RQ13] [RQ16] same bit each clock
        oe_n_q <= 1'b0;
      end else if (cmd_q == spg_pkg::OP_RD_STAT && byte_cnt_q != 3'h0) begin
        miso_q <= stat_q[~bit_ph_q];
        oe_n_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign LINK.miso = miso_q;
  assign LINK.miso_oe_n = oe_n_q;
  assign PROT_MAP = prot_q;
  assign LOCK = lock_q;
  assign WRITE_PERMIT = wpl_q;
  assign STATUS = stat_q;
endmodule // spg_dev
`default_nettype wire

// ---- verilog/spg_host.sv ----
// host controller end: wishbone registers drive serial frames to the device
`timescale 1ns/1ps
`default_nettype none
module spg_host #(
  parameter int HALF = spg_pkg::SCK_HALF
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  spg_if.host LINK
);
  typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_SHIFT = 2'b01, SH_GAP = 2'b11, SH_TAIL = 2'b10} spg_hstate_t;

  spg_hstate_t st_q;
  logic [31:0] ctrl_q, addr_q, wdat_q;
  logic [7:0] rdata_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic miso_s1_q, miso_s2_q;
  logic go;
  logic wr;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the strobe; a write lands only at the
  // edge where the master sees ack high, so a dropped request never half-writes
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q;
  assign go = wr & (WB_ADR_I == spg_pkg::REG_CTRL) & WB_SEL_I[0] & (st_q == SH_IDLE);

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= WB_CYC_I & WB_STB_I & ~ack_q;
      unique case (WB_ADR_I)
        spg_pkg::REG_CTRL: dat_q <= ctrl_q;
        spg_pkg::REG_ADDR: dat_q <= addr_q;
        spg_pkg::REG_WDATA: dat_q <= wdat_q;
        spg_pkg::REG_STAT: dat_q <= {16'h0000, rdata_q, 7'h00, st_q != SH_IDLE};
        default: dat_q <= 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // control is frozen during a frame so the pin and opcode stay stable
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= spg_pkg::CTRL_RESET;
      addr_q <= 32'h0000_0000;
      wdat_q <= 32'h0000_0000;
    end else if (wr) begin
      if (WB_ADR_I == spg_pkg::REG_CTRL && st_q == SH_IDLE) begin
        ctrl_q <= lane_merge(ctrl_q, WB_DAT_I, WB_SEL_I);
      end
      if (WB_ADR_I == spg_pkg::REG_ADDR) begin
        addr_q <= lane_merge(addr_q, WB_DAT_I, WB_SEL_I);
      end
      if (WB_ADR_I == spg_pkg::REG_WDATA) begin
        wdat_q <= lane_merge(wdat_q, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial frame engine, mode 0; the host makes the link clock
  logic [63:0] tx_q;
  logic [6:0] nbits_q, total_q;
  logic [7:0] div_q;
  logic sck_q, cs_n_q, mosi_q;
  logic [2:0] extra;
  logic [3:0] nbytes;
  logic [63:0] tx_init;
  logic [7:0] op, wd;

  // ctrl is sampled next cycle, after the starting write landed
  logic start_q;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      start_q <= 1'b0;
    end else begin
      start_q <= go;
    end
  end

  assign op = ctrl_q[spg_pkg::CT_OP_LO +: 8];
  assign wd = wdat_q[7:0];
  assign extra = (ctrl_q[spg_pkg::CT_EXTRA_LO +: 3] > 3'h4) ? 3'h4 : ctrl_q[spg_pkg::CT_EXTRA_LO +: 3];
  assign nbytes = 4'h1 + (ctrl_q[spg_pkg::CT_USE_ADDR] ? 4'h3 : 4'h0) + {1'b0, extra};
  // address bytes go msb first; the device picks the sector from them [RQ12]
  assign tx_init = ctrl_q[spg_pkg::CT_USE_ADDR] ? {op, addr_q[23:0], {4{wd}}} : {op, {7{wd}}};

  // miso is sampled just before each falling edge, giving the device
  // a whole clock period through both synchronisers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= LINK.so_line;
      miso_s2_q <= miso_s1_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= SH_IDLE;
      tx_q <= 64'h0000_0000_0000_0000;
      nbits_q <= 7'h00;
      total_q <= 7'h00;
      div_q <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      unique case (st_q)
        SH_IDLE: begin
          if (start_q) begin
            tx_q <= tx_init;
            mosi_q <= tx_init[63];
            total_q <= {nbytes, 3'h0};
            nbits_q <= 7'h00;
            div_q <= 8'h00;
            cs_n_q <= 1'b0;
            st_q <= SH_SHIFT;
          end
        end
        SH_SHIFT: begin
          if (div_q == 8'(HALF - 1)) begin
            div_q <= 8'h00;
            sck_q <= ~sck_q;
            if (sck_q) begin
              // falling edge: capture, shift out next bit
              rdata_q <= {rdata_q[6:0], miso_s2_q};
              tx_q <= {tx_q[62:0], 1'b0};
              mosi_q <= tx_q[62];
              nbits_q <= nbits_q + 7'h01;
              if (nbits_q == total_q - 7'h01) begin
                st_q <= SH_GAP; // frame ends on a byte boundary [RQ21]
              end
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        SH_GAP: begin
          if (div_q == 8'(HALF - 1)) begin
            div_q <= 8'h00;
            cs_n_q <= 1'b1;
            st_q <= SH_TAIL;
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        SH_TAIL: begin
          // keep select high long enough for the device to see it
          if (div_q == 8'(2 * HALF - 1)) begin
            div_q <= 8'h00;
            st_q <= SH_IDLE;
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; software chooses byte patterns per the host's duties [RQ6] [RQ8] [RQ14]
  logic wp_n_q;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wp_n_q <= 1'b1;
    end else begin
      wp_n_q <= ctrl_q[spg_pkg::CT_WP_N];
    end
  end

  assign LINK.cs_n = cs_n_q;
  assign LINK.sck = sck_q;
  assign LINK.mosi = mosi_q;
  assign LINK.wp_n = wp_n_q;
  assign WB_DAT_O = dat_q;
  assign WB_ACK_O = ack_q;
endmodule // spg_host
`default_nettype wire

// ---- tb/spg_chk.sv ----
// link checker: watches the serial signals between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module spg_chk (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic sck_q;
  logic [7:0] bits_q;
  logic [7:0] op_q;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////////////////
  // link clock edge finder
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) sck_q <= 1'b0;
    else sck_q <= sck;
  end
  // bits seen in the frame; saturates so a runaway frame cannot wrap to a byte boundary
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) bits_q <= 8'h00;
    else if (cs_n) bits_q <= 8'h00;
    else if (sck && !sck_q && bits_q != 8'hFF) bits_q <= bits_q + 8'h01;
  end
  // opcode as the device shifts it in, msb first
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) op_q <= 8'h00;
    else if (!cs_n && sck && !sck_q && bits_q < 8'h08) op_q <= {op_q[6:0], mosi};
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_OE_RELEASE: assert property ($rose(cs_n) |-> ##[0:8] miso_oe_n)
    else $error("serial out still driven after select rose");
  AST_OE_IDLE: assert property (cs_n [*8] |-> miso_oe_n)
    else $error("serial out driven between frames");
  AST_NO_EARLY_OUT: assert property ((!cs_n && !miso_oe_n && bits_q >= 8'h08 && op_q == spg_pkg::OP_RD_PROT)
    |-> bits_q >= 8'h20)
    else $error("protection read drives out before the last address byte");
  AST_WR_QUIET: assert property ((!cs_n && bits_q >= 8'h08 && op_q == spg_pkg::OP_WR_STAT) |-> miso_oe_n)
    else $error("status write frame drives serial out");
  AST_REPEAT_BYTE: assert property ((!cs_n && sck && !sck_q && bits_q >= 8'h21 && op_q == spg_pkg::OP_RD_PROT)
    |-> miso == $past(miso, 8))
    else $error("protection read output bit changed");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("link clock not low between frames");
  AST_SCK_HIGH: assert property ($rose(sck) |=> sck [*3])
    else $error("link clock high phase too short");
  AST_SCK_LOW: assert property ($fell(sck) |=> !sck [*3])
    else $error("link clock low phase too short");
  AST_MOSI_SETUP: assert property ($rose(sck) |-> $stable(mosi))
    else $error("serial in moved at the sampling edge");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap between frames too short");
  AST_BYTE_END: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0)
    else $error("frame ended off a byte boundary");
endmodule // spg_chk
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: software drives the host end over wishbone against the device end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, resetn, suspend, wb_cyc, wb_stb, wb_we, wb_ack, lock, write_permit, wp_v;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [63:0] prot_map;
  logic [7:0] status, rx;
  int error_cnt, num_checks;
  spg_if ifc ();
  spg_host spg_host_inst (.SYS_CLK(sys_clk), .RESETN(resetn), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r),
    .WB_ACK_O(wb_ack), .LINK(ifc.host));
  spg_dev spg_dev_inst (.SYS_CLK(sys_clk), .RESETN(resetn), .SUSPEND(suspend), .LINK(ifc.dev),
    .PROT_MAP(prot_map), .LOCK(lock), .WRITE_PERMIT(write_permit), .STATUS(status));
  spg_chk spg_chk_inst (.SYS_CLK(sys_clk), .RESETN(resetn), .cs_n(ifc.cs_n), .sck(ifc.sck),
    .mosi(ifc.mosi), .miso(ifc.miso), .miso_oe_n(ifc.miso_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // one classic cycle; the request is held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      test_done();
    end
  endtask
  // one whole link frame; busy is polled with a bound, then state is let settle
  task automatic frame(input logic [7:0] op, input logic ua, input logic [2:0] ex, input logic [23:0] ad,
    input logic [7:0] wd);
    logic [31:0] q;
    int n;
    wb_cycle(1'b1, spg_pkg::REG_ADDR, 4'hF, {8'h00, ad}, q);
    wb_cycle(1'b1, spg_pkg::REG_WDATA, 4'hF, {24'h000000, wd}, q);
    wb_cycle(1'b1, spg_pkg::REG_CTRL, 4'hF, {15'h0000, wp_v, 4'h0, ex, ua, op}, q);
    n = 0;
    do begin
      wb_cycle(1'b0, spg_pkg::REG_STAT, 4'hF, 32'h00000000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      test_done();
    end
    rx = q[15:8];
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic wr_status(input logic [7:0] b);
    frame(spg_pkg::OP_WR_EN, 1'b0, 3'h0, 24'h000000, 8'h00);
    frame(spg_pkg::OP_WR_STAT, 1'b0, 3'h1, 24'h000000, b);
  endtask
  // two output bytes: the first may be stale on a fast link, the second is the one kept
  task automatic rd_prot(input logic [23:0] ad, input logic [7:0] exp);
    frame(spg_pkg::OP_RD_PROT, 1'b1, 3'h2, ad, 8'h00);
    check(rx, exp, "protection read byte");
  endtask
  // write-protect pin level only: no SEL[0], so no frame starts
  task automatic set_wp(input logic v);
    logic [31:0] q;
    wp_v = v;
    wb_cycle(1'b1, spg_pkg::REG_CTRL, 4'h4, {15'h0000, v, 16'h0000}, q);
    repeat (4) @(posedge sys_clk);
  endtask
  // whole observable state; the status byte is rebuilt from the expected map, lock and pin
  task automatic st_check(input logic [63:0] pm, input logic lk);
    logic [1:0] sm;
    sm = (pm == '1) ? spg_pkg::SUM_ALL : (pm == '0) ? spg_pkg::SUM_NONE : spg_pkg::SUM_SOME;
    check(prot_map, pm, "sector map");
    check(lock, lk, "lock bit");
    check(write_permit, 1'b0, "write permit after write");
    check(status, {lk, 2'b00, wp_v, sm, 2'b00}, "status byte");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] keep [3];
    keep = '{8'h04, 8'h38, 8'h2C};
    sys_clk = 1'b0;
    resetn = 1'b0;
    suspend = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h00000000;
    wp_v = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    st_check('1, 1'b0);
    frame(spg_pkg::OP_WR_STAT, 1'b0, 3'h1, 24'h000000, 8'h00);
    st_check('1, 1'b0);
    frame(spg_pkg::OP_WR_EN, 1'b0, 3'h0, 24'h000000, 8'h00);
    check(write_permit, 1'b1, "permit set");
    frame(spg_pkg::OP_WR_DIS, 1'b0, 3'h0, 24'h000000, 8'h00);
    check(write_permit, 1'b0, "permit clear");
    wr_status(8'h00);
    st_check('0, 1'b0);
    rd_prot(24'h051234, 8'h00);
    // patterns that must leave the map alone
    foreach (keep[i]) begin
      wr_status(keep[i]);
      st_check('0, 1'b0);
    end
    wr_status(8'h7F);
    st_check('1, 1'b0);
    frame(spg_pkg::OP_RD_STAT, 1'b0, 3'h1, 24'h000000, 8'h00);
    check(rx, 8'h1C, "status read");
    wr_status(8'h00);
    suspend <= 1'b1;
    wr_status(8'h7F);
    st_check('0, 1'b0);
    suspend <= 1'b0;
    wr_status(8'hFF);
    st_check('1, 1'b1);
    rd_prot(24'h3F0000, 8'hFF);
    // soft lock: only the lock bit may move, and only downwards
    wr_status(8'h80);
    st_check('1, 1'b1);
    wr_status(8'h00);
    st_check('1, 1'b0);
    wr_status(8'h00);
    st_check('0, 1'b0);
    wr_status(8'hF0);
    st_check('0, 1'b1);
    // hard lock: pin low with lock set freezes everything
    set_wp(1'b0);
    wr_status(8'h7F);
    st_check('0, 1'b1);
    wr_status(8'h0F);
    st_check('0, 1'b1);
    rd_prot(24'h000000, 8'h00);
    set_wp(1'b1);
    wr_status(8'h0F);
    st_check('0, 1'b0);
    test_done();
  end
endmodule // testbench
`default_nettype wire
